// File: design/tcsp_pkg.sv
// Package of constants and carrier types for the timer/counter with shared scaler
package tcsp_pkg;

  // Width of the count register and of the shared scaler
  localparam int CNT_W = 8;
  localparam int SCL_W = 8;

  // Cycles in which counting is suppressed after a count register write
  localparam logic [1:0] WR_HOLD_CYC = 2'h2;

  // Reset values and maximum count
  localparam logic [7:0] CNT_RST  = 8'h00;
  localparam logic [7:0] SCL_RST  = 8'h00;
  localparam logic [7:0] CNT_MAX  = 8'hff;

  // Option control bits, level inputs from the core
  typedef struct packed {
    logic       clock_source_select;   // 1 = external pin, 0 = instruction cycle
    logic       edge_polarity_select;  // 1 = falling edge, 0 = rising edge
    logic       scaler_assignment;     // 1 = watchdog, 0 = timer
    logic [2:0] ratio_select;          // Ratio 2**(n+1)
  } tcsp_opt_t;

  // Count register write request
  typedef struct packed {
    logic       wr;                    // One-cycle write strobe
    logic [7:0] data;                  // Value written
  } tcsp_wr_t;

endpackage : tcsp_pkg

// File: design/tcsp_scaler.sv
// Shared 8-bit scaler with ratio tap selection
`timescale 1ns/1ns
`default_nettype none
module tcsp_scaler
  import tcsp_pkg::*;
#(
  parameter int W = SCL_W              // Scaler width
)(
  input  wire logic         clk_sys,   // System clock
  input  wire logic         rst_sync_b,// Synchronised reset, active low
  input  wire logic         step,      // Input event to divide
  input  wire logic         clr,       // Clear the scaler count
  input  wire logic [2:0]   ratio,     // Ratio select n
  output var  logic         tick       // One-cycle pulse per division period
);

  logic [W-1:0] scl_ff;
  logic [W-1:0] nxt_scl;

  // Next scaler value, rule: no software path to it
  always_comb
  begin
    nxt_scl = scl_ff + W'(1);
  end

  // Scaler count, cleared only by defined events
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      scl_ff <= SCL_RST;
    else if (clr)
      scl_ff <= SCL_RST;
    else if (step)
      scl_ff <= nxt_scl;
  end

  // Period complete when bits n..0 all roll over
  always_comb
  begin
    tick = 1'b0;
    if (step && !clr && (scl_ff[ratio] == 1'b1) && (nxt_scl[ratio] == 1'b0))
      tick = 1'b1;
  end

endmodule : tcsp_scaler
`default_nettype wire

// File: design/tcsp_timer.sv
// Top of the 8-bit timer/counter with shared prescaler
//
// Summary of operation
// - Source bit clear: count each instruction cycle when scaler is not assigned.
// - After a count register write, counting is held off two cycles.
// - Source bit set: count on the chosen edge of the external input.
// - Polarity bit clear counts rising edges, set counts falling edges.
// - One 8-bit scaler serves timer or watchdog; the other runs unscaled.
// - Assignment bit clear gives scaler to timer, set to watchdog.
// - Three ratio bits pick ratio 1:2 to 1:256 for the timer.
// - Software cannot read or write the scaler count.
// - With scaler on timer, count register writes clear the scaler.
// - With scaler on watchdog, clear-watchdog clears the scaler.
// - Wrap from ff to 00 sets the overflow flag.
// - Interrupt request only while the overflow enable bit is set.
// - Timer halts in sleep, so no overflow or wake occurs then.
`timescale 1ns/1ns
`default_nettype none
module tcsp_timer
  import tcsp_pkg::*;
(
  input  wire logic       clk_sys,              // Instruction cycle clock
  input  wire logic       rst_b,                // Asynchronous reset, active low
  input  wire tcsp_opt_t  opt,                  // Option control bits
  input  wire tcsp_wr_t   cnt_wr,               // Count register write
  input  wire logic       flag_clr,             // Software clear of overflow flag
  input  wire logic       overflow_irq_enable,  // Overflow interrupt enable
  input  wire logic       clear_watchdog_instruction, // Clear-watchdog strobe
  input  wire logic       sleep,                // Core is in sleep
  input  wire logic       external_count_input, // External count pin
  output var  logic [7:0] count_register,       // Current count
  output var  logic       overflow_flag,        // Sticky overflow flag
  output var  logic       irq,                  // Overflow interrupt request
  output var  logic       wdt_tick              // Watchdog step, scaled with scaler on watchdog, every cycle otherwise
);

  logic       rst_s1_ff;
  logic       rst_s2_ff;
  logic       rst_sync_b;
  logic       pin_s1_ff;
  logic       pin_s2_ff;
  logic       pin_s3_ff;
  logic [1:0] hold_ff;
  logic [7:0] cnt_ff;
  logic       flag_ff;
  logic       irq_ff;
  logic       wdt_ff;
  logic       wdt_raw;
  logic       src_evt;
  logic       ext_edge;
  logic       scl_step;
  logic       scl_clr;
  logic       scl_tick;
  logic       cnt_inc;
  logic       to_timer;

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_ff  <= 1'b0;
      rst_s2_ff  <= 1'b0;
    end
    else
    begin
      rst_s1_ff  <= 1'b1;
      rst_s2_ff  <= rst_s1_ff;
    end
  end

  // Released reset copy used by the rest of the block
  assign rst_sync_b = rst_s2_ff;

  // External pin synchroniser plus edge history
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
    end
    else
    begin
      pin_s1_ff <= external_count_input;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Edge detection on synchronised pin
  always_comb
  begin
    if (opt.edge_polarity_select)
      ext_edge = pin_s3_ff && !pin_s2_ff;
    else
      ext_edge = !pin_s3_ff && pin_s2_ff;
  end

  // Source selection and scaler routing
  always_comb
  begin
    to_timer = !opt.scaler_assignment;
    src_evt  = opt.clock_source_select ? ext_edge : 1'b1;
    wdt_raw  = 1'b1;
    scl_step = to_timer ? (src_evt && !sleep) : wdt_raw;
    scl_clr  = to_timer ? cnt_wr.wr : clear_watchdog_instruction;
    cnt_inc  = to_timer ? scl_tick : (src_evt && !sleep);
  end

  // Shared scaler instance
  tcsp_scaler #(
    .W          (SCL_W)
  ) i_tcsp_scaler (
    .clk_sys    (clk_sys),
    .rst_sync_b (rst_sync_b),
    .step       (scl_step),
    .clr        (scl_clr),
    .ratio      (opt.ratio_select),
    .tick       (scl_tick)
  );

  // Write inhibit counter
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      hold_ff <= 2'h0;
    else if (cnt_wr.wr)
      hold_ff <= WR_HOLD_CYC;
    else if (hold_ff != 2'h0)
      hold_ff <= hold_ff - 2'h1;
  end

  // Count register
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      cnt_ff <= CNT_RST;
    else if (cnt_wr.wr)
      cnt_ff <= cnt_wr.data;
    else if (cnt_inc && !sleep && hold_ff == 2'h0)
      cnt_ff <= cnt_ff + 8'h01;
  end

  // Overflow flag, set wins over software clear
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      flag_ff <= 1'b0;
    else if (!cnt_wr.wr && cnt_inc && !sleep && hold_ff == 2'h0 && cnt_ff == CNT_MAX)
      flag_ff <= 1'b1;
    else if (flag_clr)
      flag_ff <= 1'b0;
  end

  // Interrupt request and watchdog step outputs
  always_ff @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      irq_ff <= 1'b0;
      wdt_ff <= 1'b0;
    end
    else
    begin
      irq_ff <= flag_ff && overflow_irq_enable;
      wdt_ff <= to_timer ? wdt_raw : scl_tick;
    end
  end

  assign count_register = cnt_ff;
  assign overflow_flag  = flag_ff;
  assign irq            = irq_ff;
  assign wdt_tick       = wdt_ff;

  // Checks
  overflow_set_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (cnt_ff == CNT_MAX && cnt_inc && !sleep && hold_ff == 2'h0 && !cnt_wr.wr)
      |=> (flag_ff && cnt_ff == 8'h00))
    else $error("overflow did not set flag");
  irq_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    irq_ff |-> ($past(flag_ff) && $past(overflow_irq_enable)))
    else $error("irq without enabled flag");
  write_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (cnt_wr.wr ##1 (!cnt_wr.wr) [*2]) |=> (cnt_ff == $past(cnt_ff, 2)))
    else $error("count moved during write hold");
  sleep_halt_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (sleep && !cnt_wr.wr) |=> $stable(cnt_ff))
    else $error("count moved in sleep");
  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (flag_ff && !flag_clr) |=> flag_ff)
    else $error("flag cleared by hardware");
  timer_rate_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (!opt.clock_source_select && opt.scaler_assignment && !sleep
     && hold_ff == 2'h0 && !cnt_wr.wr) |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("timer mode did not step");
  scaler_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (to_timer && cnt_wr.wr) |=> i_tcsp_scaler.scl_ff == SCL_RST)
    else $error("write did not clear scaler");
  wdt_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
    (!to_timer && clear_watchdog_instruction) |=> i_tcsp_scaler.scl_ff == SCL_RST)
    else $error("clear-watchdog did not clear scaler");

endmodule : tcsp_timer
`default_nettype wire

// File: testbench/tcsp_pulse_src.sv
// Pulse source model for the external count pin
`timescale 1ns/1ns
`default_nettype none
module tcsp_pulse_src
(
  input  wire logic clk_sys, // Clock
  input  wire logic rst_b,   // Reset, active low
  input  wire logic go,      // Step the waveform while high
  output var  logic pin      // External count pin
);
  logic [1:0] ph_ff;         // Waveform phase

  // Each level stands two cycles so the synchroniser sees it
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      ph_ff <= 2'h0;
    else if (go)
      ph_ff <= ph_ff + 2'h1;
  end

  // Pin holds its level between bursts
  assign pin = ph_ff[1];
endmodule : tcsp_pulse_src
`default_nettype wire

// File: testbench/tcsp_timer_test.sv
// Self-checking bench for the timer/counter with shared scaler
`timescale 1ns/1ns
`default_nettype none
module tcsp_timer_test
  import tcsp_pkg::*;
;
  logic       clk_sys, rst_b, flag_clr, ien, cwd, sleep, go, pin, flag, irq, wdt;
  tcsp_opt_t  opt;
  tcsp_wr_t   wr;
  logic [7:0] cnt;
  int         n_mismatch, cmp_count, p;

  // Device and pin source
  tcsp_timer i_tcsp_timer (.clk_sys(clk_sys), .rst_b(rst_b), .opt(opt), .cnt_wr(wr),
    .flag_clr(flag_clr), .overflow_irq_enable(ien), .clear_watchdog_instruction(cwd),
    .sleep(sleep), .external_count_input(pin), .count_register(cnt),
    .overflow_flag(flag), .irq(irq), .wdt_tick(wdt));
  tcsp_pulse_src i_tcsp_pulse_src (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .pin(pin));

  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc

  // Cycles between two count changes, or between two watchdog steps
  task automatic per(input logic w, output int q);
    logic [7:0] c0;
    int         k;
    for (int j = 0; j < 2; j++)
    begin
      c0 = cnt;
      q = 0;
      for (k = 0; k < 600; k++)
      begin
        cyc(1);
        q++;
        if (w ? (wdt === 1'b1) : (cnt !== c0))
          break;
      end
      if (k == 600)
      begin
        n_mismatch++;
        end_sim();
      end
    end
  endtask : per

  task automatic wr_cnt(input logic [7:0] d);
    wr = '{1'b1, d};
    cyc(1);
    wr.wr = 1'b0;
  endtask : wr_cnt

  // Write hold, overflow, interrupt mask, flag clear, sleep
  task automatic t_ovf();
    logic [7:0] c;
    opt = '{1'b0, 1'b0, 1'b1, 3'h0};
    ien = 1'b1;
    wr_cnt(8'hf0);
    chk(cnt, 8'hf0);
    cyc(1);
    chk(cnt, 8'hf0);
    per(1'b0, p);
    chk(8'(p), 8'h01);
    for (int k = 0; k < 40 && flag !== 1'b1; k++) cyc(1);
    chk(cnt, 8'h00);
    chk({7'h0, flag}, 8'h01);
    cyc(1);
    chk({7'h0, irq}, 8'h01);
    ien = 1'b0;
    cyc(2);
    chk({7'h0, irq}, 8'h00);
    chk({7'h0, flag}, 8'h01);
    flag_clr = 1'b1;
    cyc(1);
    flag_clr = 1'b0;
    cyc(1);
    chk({7'h0, flag}, 8'h00);
    sleep = 1'b1;
    cyc(2);
    c = cnt;
    cyc(300);
    chk(cnt, c);
    chk({7'h0, flag}, 8'h00);
    sleep = 1'b0;
    $display("test overflow done");
  endtask : t_ovf

  // Every timer ratio
  task automatic t_scale();
    opt = '{1'b0, 1'b0, 1'b0, 3'h0};
    cyc(1);
    chk({7'h0, wdt}, 8'h01);
    for (int n = 0; n < 8; n++)
    begin
      opt.ratio_select = 3'(n);
      wr_cnt(8'h00);
      per(1'b0, p);
      chk(8'(p == (2 << n)), 8'h01);
    end
    $display("test ratios done");
  endtask : t_scale

  // Scaler on the watchdog and its clear
  task automatic t_wdog();
    opt = '{1'b0, 1'b0, 1'b1, 3'h2};
    per(1'b1, p);
    chk(8'(p), 8'h08);
    per(1'b0, p);
    chk(8'(p), 8'h01);
    per(1'b1, p);
    cyc(2);
    cwd = 1'b1;
    cyc(1);
    cwd = 1'b0;
    for (p = 1; p < 20 && wdt !== 1'b1; p++) cyc(1);
    chk(8'(p > 6), 8'h01);
    $display("test watchdog done");
  endtask : t_wdog

  // Counter mode: burst gives two rising, one falling, then the reverse
  task automatic t_ext(input logic pol, input logic [7:0] add);
    logic [7:0] c;
    opt = '{1'b1, pol, 1'b1, 3'h0};
    cyc(4);
    c = cnt;
    go = 1'b1;
    cyc(6);
    go = 1'b0;
    cyc(6);
    chk(cnt, c + add);
    $display("test external done");
  endtask : t_ext

  // Reset, then the tests
  initial
  begin
    n_mismatch = 0;
    cmp_count = 0;
    {rst_b, flag_clr, ien, cwd, sleep, go} = 6'h00;
    opt = '0;
    wr = '0;
    cyc(2);
    rst_b = 1'b1;
    cyc(3);
    t_ovf();
    t_scale();
    t_wdog();
    t_ext(1'b0, 8'h02);
    t_ext(1'b1, 8'h02);
    end_sim();
  end
endmodule : tcsp_timer_test
`default_nettype wire
